// file: common/pdc_pkg.sv
// constants for the synthesizer-loop divider configuration bank
// assumes registers are 8 bits wide, one per aligned 32-bit word
package pdc_pkg;

	localparam int unsigned NUM_REGS = 16;

	// register indices; byte address = 4 * index
	localparam logic [9:0] IDX_LOOP_CTRL   = 10'h101;
	localparam logic [9:0] IDX_BYPASS      = 10'h104;
	localparam logic [9:0] IDX_REF_DIV     = 10'h105;
	localparam logic [9:0] IDX_FB_INT      = 10'h107;
	localparam logic [9:0] IDX_FRAC0       = 10'h108;
	localparam logic [9:0] IDX_FRAC1       = 10'h109;
	localparam logic [9:0] IDX_FRAC2       = 10'h10a;
	localparam logic [9:0] IDX_MOD0        = 10'h10b;
	localparam logic [9:0] IDX_MOD1        = 10'h10c;
	localparam logic [9:0] IDX_MOD2        = 10'h10d;
	localparam logic [9:0] IDX_CAS_LO      = 10'h10e;
	localparam logic [9:0] IDX_CAS_HI      = 10'h10f;
	localparam logic [9:0] IDX_FD_RATIO    = 10'h110;
	localparam logic [9:0] IDX_FD_PHASE    = 10'h111;
	localparam logic [9:0] IDX_VCO_CTRL    = 10'h120;
	localparam logic [9:0] IDX_VCO_RATIO   = 10'h121;
	localparam logic [9:0] IDX_SYNC_MASK   = 10'h122;

	// storage slots
	localparam logic [3:0] SL_LOOP_CTRL = 4'h0;
	localparam logic [3:0] SL_BYPASS    = 4'h1;
	localparam logic [3:0] SL_REF_DIV   = 4'h2;
	localparam logic [3:0] SL_FB_INT    = 4'h3;
	localparam logic [3:0] SL_FRAC0     = 4'h4;
	localparam logic [3:0] SL_FRAC1     = 4'h5;
	localparam logic [3:0] SL_FRAC2     = 4'h6;
	localparam logic [3:0] SL_MOD0      = 4'h7;
	localparam logic [3:0] SL_MOD1      = 4'h8;
	localparam logic [3:0] SL_MOD2      = 4'h9;
	localparam logic [3:0] SL_CAS_LO    = 4'ha;
	localparam logic [3:0] SL_CAS_HI    = 4'hb;
	localparam logic [3:0] SL_FD_RATIO  = 4'hc;
	localparam logic [3:0] SL_FD_PHASE  = 4'hd;
	localparam logic [3:0] SL_VCO_CTRL  = 4'he;
	localparam logic [3:0] SL_VCO_RATIO = 4'hf;
	// sync mask lives outside the array
	localparam logic [9:0] SLOT_IDX [NUM_REGS] = '{
		IDX_LOOP_CTRL, IDX_BYPASS, IDX_REF_DIV, IDX_FB_INT,
		IDX_FRAC0, IDX_FRAC1, IDX_FRAC2, IDX_MOD0,
		IDX_MOD1, IDX_MOD2, IDX_CAS_LO, IDX_CAS_HI,
		IDX_FD_RATIO, IDX_FD_PHASE, IDX_VCO_CTRL, IDX_VCO_RATIO};
	localparam logic [7:0] SLOT_RST [NUM_REGS] = '{
		8'h01, 8'h00, 8'h01, 8'h64, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h44};
	localparam logic [7:0] SLOT_WMSK [NUM_REGS] = '{
		8'h07, 8'h01, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'hff, 8'hff, 8'h0f, 8'h3f, 8'h3f, 8'h77, 8'hff};
	localparam logic [7:0] RST_SYNC_MASK = 8'h00;
	localparam logic [7:0] WMSK_SYNC_MASK = 8'h7f;

	// field positions
	localparam int unsigned LC_SDM_PD   = 0;
	localparam int unsigned LC_MODE_LSB = 1;
	localparam int unsigned VC_A_RST    = 0;
	localparam int unsigned VC_A_PD     = 1;
	localparam int unsigned VC_A_SYNC   = 2;
	localparam int unsigned VC_B_RST    = 4;
	localparam int unsigned VC_B_PD     = 5;
	localparam int unsigned VC_B_SYNC   = 6;
	localparam int unsigned MK_B_CH1    = 5;
	localparam int unsigned MK_B_CH2    = 6;

	localparam logic [3:0] VDIV_MIN = 4'h2;
	localparam logic [3:0] VDIV_MAX = 4'hb;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		PDC_LOOP_SINGLE  = 2'b00,
		PDC_LOOP_CASCADE = 2'b01,
		PDC_LOOP_FIXED   = 2'b10,
		PDC_LOOP_RSVD    = 2'b11
	} pdc_loop_t;

	// vco divider runs only for ratios 2..11
	function automatic logic pdc_vdiv_live(input logic [3:0] r);
		pdc_vdiv_live = (r >= VDIV_MIN) && (r <= VDIV_MAX);
	endfunction : pdc_vdiv_live

endpackage : pdc_pkg

// file: common/pdc_sdm_if.sv
// settings and result between the register bank and the modulator
// assumes one clock shared by both ends
`timescale 1ns/1ns
interface pdc_sdm_if;
	logic [7:0]  int_val;
	logic [23:0] frac;
	logic [23:0] modu;
	logic        pd;
	logic        step;
	logic [8:0]  ratio;
	modport cfg  (output int_val, frac, modu, pd, step, input ratio);
	modport core (input int_val, frac, modu, pd, step, output ratio);
endinterface : pdc_sdm_if

// file: design/pdc_bank.sv
// divider configuration register bank of the fractional synthesizer loop
// assumes an AXI4-Lite master on the same clock and a feedback tick input
`timescale 1ns/1ns

// Overview of operation
// - bypass bit set routes around the loop filter; resets clear.
// - reference predivider divides by its six-bit field; resets to one; zero reserved.
// - main feedback divides by the eight-bit integer plus the modulator carry; resets to 0x64.
// - fraction is three bytes, low address least significant; all reset zero.
// - cascade ratio is twelve bits over two registers; 4 to 4095 legal.
// - fixed-delay divider divides by field plus one; resets to zero.
// - fixed-delay start phase is six bits of input half-periods.
// - vco divider b sync holds its fed channel dividers in reset.
// - vco divider a sync holds its fed channel dividers in reset.
// - each vco divider has a reset bit; one holds it; resets zero.
// - vco ratios 2 to 11 divide; other values power down; reset four.
// - five masks let channels 0-3 and fixed-delay ignore divider a sync.
// - two masks let channels 1 and 2 ignore divider b sync.
// - two-bit loop mode picks single, cascade or fixed-delay feedback.
// - modulator power-down bit resets set, giving integer-only feedback.
module pdc_bank
	import pdc_pkg::*;
#(
	parameter int unsigned ADDR_W = 12
) (
	input  wire logic              i_core_clk,
	input  wire logic              i_nrst,
	input  wire logic              i_ce,
	input  wire logic [ADDR_W-1:0] i_awaddr,
	input  wire logic              i_awvalid,
	output logic                   o_awready,
	input  wire logic [31:0]       i_wdata,
	input  wire logic [3:0]        i_wstrb,
	input  wire logic              i_wvalid,
	output logic                   o_wready,
	output logic [1:0]             o_bresp,
	output logic                   o_bvalid,
	input  wire logic              i_bready,
	input  wire logic [ADDR_W-1:0] i_araddr,
	input  wire logic              i_arvalid,
	output logic                   o_arready,
	output logic [31:0]            o_rdata,
	output logic [1:0]             o_rresp,
	output logic                   o_rvalid,
	input  wire logic              i_rready,
	input  wire logic              i_fb_tick,
	output logic                   o_loop_bypass,
	output logic [5:0]             o_ref_div_ratio,
	output logic [1:0]             o_loop_mode,
	output logic [11:0]            o_fb_ratio,
	output logic [5:0]             o_fixed_phase,
	output logic [1:0]             o_vco_rst,
	output logic [1:0]             o_vco_pd,
	output logic [3:0]             o_vco_ratio_a,
	output logic [3:0]             o_vco_ratio_b,
	output logic [4:0]             o_chan_hold
);

	if (ADDR_W < 12) begin : g_chk
		$error("ADDR_W too small for register map");
	end

	function automatic logic [4:0] slot_of(input logic [ADDR_W-1:0] a);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (a[ADDR_W-1:2] == {{(ADDR_W-12){1'b0}}, SLOT_IDX[i]} && a[1:0] == 2'b00) begin
				r = {1'b1, 4'(i)};
			end
		end
		slot_of = r;
	endfunction : slot_of

	function automatic logic hits_mask(input logic [ADDR_W-1:0] a);
		hits_mask = (a == {{(ADDR_W-12){1'b0}}, IDX_SYNC_MASK, 2'b00});
	endfunction : hits_mask

	logic [7:0]  regs_r [NUM_REGS];
	logic [7:0]  mask_r;
	logic [23:0] frac_act_r;
	logic [23:0] mod_act_r;
	logic [11:0] cas_act_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [1:0]  rresp_r;
	logic [31:0] rdata_r;

	wire         wr_go;
	wire         rd_go;
	wire  [4:0]  wslot;
	wire  [4:0]  rslot;
	wire         w_mask_hit;
	wire         r_mask_hit;
	wire         w_mapped;
	wire         r_mapped;
	wire         wr_en;
	wire  [7:0]  wbyte;
	wire  [7:0]  rbyte;
	wire  [7:0]  vctl;
	wire  [7:0]  vrat;
	pdc_loop_t   loop_mode;
	wire  [11:0] fb_sel;
	wire  [4:0]  hold_a;
	wire  [4:0]  hold_b;
	wire         sync_a;
	wire         sync_b;

	pdc_sdm_if sdm ();

	// write address and data are taken together in one beat
	assign wr_go      = i_ce && i_awvalid && i_wvalid && !bvalid_r;
	assign rd_go      = i_ce && i_arvalid && !rvalid_r;
	assign o_awready  = wr_go;
	assign o_wready   = wr_go;
	assign o_arready  = rd_go;
	assign o_bvalid   = bvalid_r;
	assign o_bresp    = bresp_r;
	assign o_rvalid   = rvalid_r;
	assign o_rresp    = rresp_r;
	assign o_rdata    = rdata_r;

	assign wslot      = slot_of(i_awaddr);
	assign rslot      = slot_of(i_araddr);
	assign w_mask_hit = hits_mask(i_awaddr);
	assign r_mask_hit = hits_mask(i_araddr);
	assign w_mapped   = wslot[4] || w_mask_hit;
	assign r_mapped   = rslot[4] || r_mask_hit;
	assign wr_en      = wr_go && i_wstrb[0];
	assign wbyte      = i_wdata[7:0];
	assign rbyte      = r_mask_hit ? mask_r : (rslot[4] ? regs_r[rslot[3:0]] : 8'h00);

	assign vctl       = regs_r[SL_VCO_CTRL];
	assign vrat       = regs_r[SL_VCO_RATIO];
	assign loop_mode  = pdc_loop_t'(regs_r[SL_LOOP_CTRL][LC_MODE_LSB +: 2]);
	assign sync_a     = vctl[VC_A_SYNC];
	assign sync_b     = vctl[VC_B_SYNC];

	// channel 0..3 in bits 0..3, fixed-delay divider in bit 4
	assign hold_a = {5{sync_a}} & ~mask_r[4:0];
	assign hold_b = {2'b00, sync_b && !mask_r[MK_B_CH2], sync_b && !mask_r[MK_B_CH1], 1'b0};

	// feedback path select; reserved code gives no ratio
	assign fb_sel = (loop_mode == PDC_LOOP_SINGLE)  ? {3'h0, sdm.ratio} :
	                (loop_mode == PDC_LOOP_CASCADE) ? cas_act_r :
	                (loop_mode == PDC_LOOP_FIXED)   ?
	                 {6'h00, regs_r[SL_FD_RATIO][5:0]} + 12'h001 : 12'h000;

	assign sdm.int_val = regs_r[SL_FB_INT];
	assign sdm.frac    = frac_act_r;
	assign sdm.modu    = mod_act_r;
	assign sdm.pd      = regs_r[SL_LOOP_CTRL][LC_SDM_PD];
	assign sdm.step    = i_fb_tick;

	pdc_sdm u_sdm (
		.i_core_clk (i_core_clk),
		.i_nrst     (i_nrst),
		.i_ce       (i_ce),
		.sdm        (sdm)
	);

	// register store; reserved bits masked off on write
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			regs_r <= SLOT_RST;
			mask_r <= RST_SYNC_MASK;
		end else if (wr_en && wslot[4]) begin
			regs_r[wslot[3:0]] <= wbyte & SLOT_WMSK[wslot[3:0]];
		end else if (wr_en && w_mask_hit) begin
			mask_r <= wbyte & WMSK_SYNC_MASK;
		end
	end

	// wide fields take effect when their top byte is written
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			frac_act_r <= 24'h000000;
			mod_act_r  <= 24'h000000;
			cas_act_r  <= 12'h000;
		end else if (wr_en && wslot[4]) begin
			if (wslot[3:0] == SL_FRAC2) begin
				frac_act_r <= {wbyte, regs_r[SL_FRAC1], regs_r[SL_FRAC0]};
			end
			if (wslot[3:0] == SL_MOD2) begin
				mod_act_r <= {wbyte, regs_r[SL_MOD1], regs_r[SL_MOD0]};
			end
			if (wslot[3:0] == SL_CAS_HI) begin
				cas_act_r <= {wbyte[3:0], regs_r[SL_CAS_LO]};
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (i_ce && i_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rvalid_r <= 1'b0;
			rresp_r  <= RESP_OKAY;
			rdata_r  <= 32'h00000000;
		end else if (rd_go) begin
			rvalid_r <= 1'b1;
			rresp_r  <= r_mapped ? RESP_OKAY : RESP_SLVERR;
			rdata_r  <= {24'h000000, rbyte};
		end else if (i_ce && i_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// registered controls toward the analog blocks
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_loop_bypass   <= 1'b0;
			o_ref_div_ratio <= 6'h01;
			o_loop_mode     <= 2'b00;
			o_fb_ratio      <= 12'h000;
			o_fixed_phase   <= 6'h00;
			o_vco_rst       <= 2'b00;
			o_vco_pd        <= 2'b10;
			o_vco_ratio_a   <= 4'h4;
			o_vco_ratio_b   <= 4'h4;
			o_chan_hold     <= 5'h00;
		end else if (i_ce) begin
			o_loop_bypass   <= regs_r[SL_BYPASS][0];
			o_ref_div_ratio <= regs_r[SL_REF_DIV][5:0];
			o_loop_mode     <= loop_mode;
			o_fb_ratio      <= fb_sel;
			o_fixed_phase   <= regs_r[SL_FD_PHASE][5:0];
			o_vco_rst       <= {vctl[VC_B_RST], vctl[VC_A_RST]};
			o_vco_pd[0]     <= vctl[VC_A_PD] || !pdc_vdiv_live(vrat[3:0]);
			o_vco_pd[1]     <= vctl[VC_B_PD] || !pdc_vdiv_live(vrat[7:4]);
			o_vco_ratio_a   <= vrat[3:0];
			o_vco_ratio_b   <= vrat[7:4];
			o_chan_hold     <= hold_a | hold_b;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	property p_bypass;
		(wr_en && wslot == {1'b1, SL_BYPASS}) ##1 i_ce |=>
			(o_loop_bypass == $past(i_wdata[0], 2));
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass did not follow write");

	property p_single_ratio;
		($past(i_ce) && $past(loop_mode) == PDC_LOOP_SINGLE) |->
			(o_fb_ratio == {3'h0, $past(sdm.ratio)});
	endproperty
	a_single_ratio: assert property (p_single_ratio) else $error("single mode ratio wrong");

	property p_fixed_ratio;
		($past(i_ce) && $past(loop_mode) == PDC_LOOP_FIXED) |->
			(o_fb_ratio == {6'h00, $past(regs_r[SL_FD_RATIO][5:0])} + 12'h001);
	endproperty
	a_fixed_ratio: assert property (p_fixed_ratio) else $error("fixed-delay ratio not plus one");

	property p_hold_a;
		(i_ce && sync_a && !mask_r[0]) |=> o_chan_hold[0];
	endproperty
	a_hold_a: assert property (p_hold_a) else $error("channel 0 not held by sync a");

	property p_hold_b;
		(i_ce && sync_b && !mask_r[MK_B_CH1]) |=> o_chan_hold[1];
	endproperty
	a_hold_b: assert property (p_hold_b) else $error("channel 1 not held by sync b");

	property p_mask_a;
		(i_ce && sync_a && mask_r[3]) |=> !o_chan_hold[3];
	endproperty
	a_mask_a: assert property (p_mask_a) else $error("masked channel 3 held");

	property p_mask_b;
		(i_ce && !sync_a && mask_r[MK_B_CH2]) |=> !o_chan_hold[2];
	endproperty
	a_mask_b: assert property (p_mask_b) else $error("masked channel 2 held");

	property p_vco_rst;
		$past(i_ce) |-> (o_vco_rst == {$past(vctl[VC_B_RST]), $past(vctl[VC_A_RST])});
	endproperty
	a_vco_rst: assert property (p_vco_rst) else $error("vco reset not applied");

	property p_vco_pd;
		(i_ce && (vrat[3:0] < VDIV_MIN || vrat[3:0] > VDIV_MAX)) |=> o_vco_pd[0];
	endproperty
	a_vco_pd: assert property (p_vco_pd) else $error("invalid ratio not powered down");

	property p_frac_commit;
		$changed(frac_act_r) |-> $past(wr_en && wslot == {1'b1, SL_FRAC2});
	endproperty
	a_frac_commit: assert property (p_frac_commit) else $error("fraction changed early");

	property p_rsvd;
		((regs_r[SL_VCO_CTRL] & ~SLOT_WMSK[SL_VCO_CTRL]) == 8'h00) && (mask_r[7] == 1'b0);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

	property p_ref_div;
		$past(i_ce) |-> (o_ref_div_ratio == $past(regs_r[SL_REF_DIV][5:0]));
	endproperty
	a_ref_div: assert property (p_ref_div) else $error("ref predivider ratio not applied");

	property p_phase;
		$past(i_ce) |-> (o_fixed_phase == $past(regs_r[SL_FD_PHASE][5:0]));
	endproperty
	a_phase: assert property (p_phase) else $error("fixed-delay phase not applied");

	property p_mode;
		$past(i_ce) |-> (o_loop_mode == $past(loop_mode));
	endproperty
	a_mode: assert property (p_mode) else $error("loop mode not applied");

	property p_cas_ratio;
		($past(i_ce) && $past(loop_mode) == PDC_LOOP_CASCADE) |->
			(o_fb_ratio == $past(cas_act_r));
	endproperty
	a_cas_ratio: assert property (p_cas_ratio) else $error("cascade ratio not selected");

	property p_cas_commit;
		$changed(cas_act_r) |-> $past(wr_en && wslot == {1'b1, SL_CAS_HI});
	endproperty
	a_cas_commit: assert property (p_cas_commit) else $error("cascade changed early");

	property p_mod_commit;
		$changed(mod_act_r) |-> $past(wr_en && wslot == {1'b1, SL_MOD2});
	endproperty
	a_mod_commit: assert property (p_mod_commit) else $error("modulus changed early");

	property p_frac_order;
		$past(wr_en && wslot == {1'b1, SL_FRAC2}) |->
			(frac_act_r == {$past(wbyte), $past(regs_r[SL_FRAC1]), $past(regs_r[SL_FRAC0])});
	endproperty
	a_frac_order: assert property (p_frac_order) else $error("fraction byte order wrong");

	property p_rdata_rsvd;
		rvalid_r |-> (rdata_r[31:8] == 24'h000000);
	endproperty
	a_rdata_rsvd: assert property (p_rdata_rsvd) else $error("upper read bits not zero");

endmodule : pdc_bank

// file: design/pdc_sdm.sv
// first-order sigma-delta modulator for the feedback divider
// assumes step pulses once per feedback divider cycle
`timescale 1ns/1ns
module pdc_sdm
	import pdc_pkg::*;
(
	input  wire logic  i_core_clk,
	input  wire logic  i_nrst,
	input  wire logic  i_ce,
	pdc_sdm_if.core    sdm
);
	logic [23:0] acc_r;
	logic [8:0]  ratio_r;
	logic [24:0] sum;
	logic        wrap;
	logic        run;

	assign run  = !sdm.pd && (sdm.modu != 24'h000000) && (sdm.frac < sdm.modu);
	assign sum  = {1'b0, acc_r} + {1'b0, sdm.frac};
	assign wrap = sum >= {1'b0, sdm.modu};
	assign sdm.ratio = ratio_r;

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			acc_r   <= 24'h000000;
			ratio_r <= 9'h000;
		end else if (i_ce) begin
			if (!run) begin
				acc_r   <= 24'h000000;
				ratio_r <= {1'b0, sdm.int_val};
			end else if (sdm.step) begin
				acc_r   <= wrap ? 24'(sum - {1'b0, sdm.modu}) : sum[23:0];
				ratio_r <= {1'b0, sdm.int_val} + {8'h00, wrap};
			end
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	property p_sdm_pd_int;
		(i_ce && sdm.pd) |=> (ratio_r == {1'b0, $past(sdm.int_val)});
	endproperty
	a_sdm_pd_int: assert property (p_sdm_pd_int) else $error("sdm not integer when off");

	property p_sdm_span;
		(i_ce && run && sdm.step) |=>
			(ratio_r - {1'b0, $past(sdm.int_val)} <= 9'h001);
	endproperty
	a_sdm_span: assert property (p_sdm_span) else $error("sdm ratio out of span");

endmodule : pdc_sdm

// file: verif/tb_pdc_bank.sv
// self-checking bench for the divider configuration bank
// assumes pdc_pkg and the bank design are compiled first
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_pdc_bank
	import pdc_pkg::*;
;
	logic        clk, i_nrst, ce, awvalid, wvalid, bready, arvalid, rready, tick;
	logic [11:0] awaddr, araddr, fb, casc;
	logic [31:0] wdata, rdata, q, sum, checks, errors, cyc, seed, tcnt;
	logic [3:0]  wstrb, ra, rb;
	logic        awready, wready, bvalid, arready, rvalid, bypass;
	logic [1:0]  bresp, rresp, mode, vrst, vpd, r;
	logic [5:0]  refd, phase;
	logic [4:0]  hold;
	logic [7:0]  shd [17];
	logic [7:0]  d;
	int          s;

	pdc_bank #(.ADDR_W(12)) u_pdc_bank (.i_core_clk(clk), .i_nrst(i_nrst), .i_ce(ce),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready), .i_fb_tick(tick), .o_loop_bypass(bypass),
		.o_ref_div_ratio(refd), .o_loop_mode(mode), .o_fb_ratio(fb),
		.o_fixed_phase(phase), .o_vco_rst(vrst), .o_vco_pd(vpd), .o_vco_ratio_a(ra),
		.o_vco_ratio_b(rb), .o_chan_hold(hold));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// feedback tick every fourth cycle
	always @(posedge clk) begin
		if (!i_nrst) begin
			tcnt <= 32'h0;
			tick <= 1'b0;
		end else begin
			tcnt <= tcnt + 32'h1;
			tick <= (tcnt[1:0] == 2'b11);
		end
	end

	always @(posedge clk) begin
		if (!i_nrst)
			cyc <= 32'h0;
		else
			cyc <= cyc + 32'h1;
		if (cyc == 32'd20000) begin
			errors++;
			end_sim();
		end
	end

	function automatic logic [11:0] adr(input int k);
		adr = (k == 16) ? {IDX_SYNC_MASK, 2'b00} : {SLOT_IDX[k], 2'b00};
	endfunction : adr

	function automatic logic [7:0] wm(input int k);
		wm = (k == 16) ? WMSK_SYNC_MASK : SLOT_WMSK[k];
	endfunction : wm

	function automatic logic [7:0] rv(input int k);
		rv = (k == 16) ? RST_SYNC_MASK : SLOT_RST[k];
	endfunction : rv

	function automatic logic dead(input logic [3:0] v);
		dead = (v < 4'h2) || (v > 4'hb);
	endfunction : dead

	task automatic end_sim();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	task automatic axw(input logic [11:0] a, input logic [7:0] v, input logic [3:0] st,
		input bit stl, output logic [1:0] rsp);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= {24'h0, v};
		wstrb   <= st;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		if (stl) begin
			ce <= 1'b0;
			repeat (3) begin
				@(negedge clk);
				`CHK(awready, 1'b0)
			end
			@(posedge clk);
			ce <= 1'b1;
		end
		do @(negedge clk); while ((awready & wready) !== 1'b1);
		@(posedge clk);
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		do @(negedge clk); while (bvalid !== 1'b1);
		rsp = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rsp);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(negedge clk); while (arready !== 1'b1);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (rvalid !== 1'b1);
		v = rdata;
		rsp = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask : axr

	// write one register, mirror it, read it back
	task automatic wr(input int k, input logic [7:0] v, input bit stl);
		logic [1:0]  rs;
		logic [31:0] rd;
		axw(adr(k), v, 4'hf, stl, rs);
		`CHK(rs, RESP_OKAY)
		shd[k] = v & wm(k);
		if (k == 11)
			casc = {shd[11][3:0], shd[10]};
		axr(adr(k), rd, rs);
		`CHK(rd, {24'h0, shd[k]})
	endtask : wr

	task automatic chk_outs();
		logic [11:0] f;
		logic        a_s, b_s;
		logic [7:0]  m;
		a_s = shd[14][2];
		b_s = shd[14][6];
		m = shd[16];
		case (shd[0][2:1])
			2'b00: f = {4'h0, shd[3]};
			2'b01: f = casc;
			2'b10: f = {6'h0, shd[12][5:0]} + 12'h1;
			default: f = 12'h0;
		endcase
		repeat (4) @(posedge clk);
		@(negedge clk);
		`CHK(bypass, shd[1][0])
		`CHK(refd, shd[2][5:0])
		`CHK(mode, shd[0][2:1])
		`CHK(fb, f)
		`CHK(phase, shd[13][5:0])
		`CHK(vrst, {shd[14][4], shd[14][0]})
		`CHK(vpd, {shd[14][5] | dead(shd[15][7:4]), shd[14][1] | dead(shd[15][3:0])})
		`CHK({rb, ra}, shd[15])
		`CHK(hold, {a_s & !m[4], a_s & !m[3], (a_s & !m[2]) | (b_s & !m[6]),
			(a_s & !m[1]) | (b_s & !m[5]), a_s & !m[0]})
	endtask : chk_outs

	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{checks, errors, casc} = '0;
		ce = 1'b1;
		i_nrst = 1'b0;
		seed = 32'd79;
		repeat (3) @(posedge clk);
		i_nrst <= 1'b1;
		for (s = 0; s < 17; s++) begin
			shd[s] = rv(s);
			axr(adr(s), q, r);
			`CHK(q, {24'h0, rv(s)})
		end
		chk_outs();
		for (s = 0; s < 17; s++)
			wr(s, 8'hff, 1'b0);
		chk_outs();
		for (int i = 0; i < 60; i++) begin
			s = {$random(seed)} % 17;
			d = 8'($random(seed));
			if (s == 0)
				d[0] = 1'b1;
			if (s == 2 && d[5:0] == 6'h00)
				d[0] = 1'b1;
			if (s == 3 && d < 8'h0c)
				d = d + 8'h0c;
			if (s == 11)
				d[0] = 1'b1;
			wr(s, d, i % 10 == 0);
			chk_outs();
		end
		axw(adr(3), 8'h5a, 4'he, 1'b0, r);
		`CHK(r, RESP_OKAY)
		axw({10'h106, 2'b00}, 8'h01, 4'hf, 1'b0, r);
		`CHK(r, RESP_SLVERR)
		axw(adr(1) | 12'h1, 8'h01, 4'hf, 1'b0, r);
		`CHK(r, RESP_SLVERR)
		axr({10'h106, 2'b00}, q, r);
		`CHK({q, r}, {32'h0, RESP_SLVERR})
		axr(adr(3), q, r);
		`CHK(q, {24'h0, shd[3]})
		chk_outs();
		// cascade, fixed-delay and single-mode modulator feedback paths
		wr(0, 8'h03, 1'b0);
		chk_outs();
		wr(0, 8'h05, 1'b0);
		chk_outs();
		wr(3, 8'h64, 1'b0);
		wr(4, 8'h02, 1'b0);
		wr(5, 8'h00, 1'b0);
		wr(6, 8'h00, 1'b0);
		wr(7, 8'h05, 1'b0);
		wr(8, 8'h00, 1'b0);
		wr(9, 8'h00, 1'b0);
		wr(0, 8'h00, 1'b0);
		for (int j = 0; j < 3; j++) begin
			if (j == 1)
				wr(4, 8'h03, 1'b0);
			if (j == 2)
				wr(6, 8'h00, 1'b0);
			repeat (60) @(posedge clk);
			sum = 32'h0;
			repeat (10) begin
				do @(negedge clk); while (tick !== 1'b1);
				sum = sum + {20'h0, fb};
			end
			`CHK(sum, (j == 2) ? 32'h3ee : 32'h3ec)
		end
		end_sim();
	end
endmodule : tb_pdc_bank
